/* File: rtl/afv_top.sv */
/*
 * analog value formatter: per-channel configuration, settling window,
 * image words, sticky events with interrupt, avalon-mm register slave.
 * assumes converter results arrive synchronous to clk as one-cycle pulses.
 */
// The address map and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module afv_top #(
  parameter int unsigned SETTLE_CYC = afv_pkg::SETTLE_CYC
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // converter results
  input  wire afv_pkg::afv_conv_s conv,
  // avalon-mm slave
  input  wire logic [3:0]        address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  output logic [31:0]            readdata,
  output logic                   waitrequest,
  // interrupt
  output logic                   irq
);
  import afv_pkg::*;

  // ----------------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) rst_sync_q <= 2'b00;
    else       rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [7:0]          code_q   [NUM_CH];
  logic [7:0]          code_d   [NUM_CH];
  afv_mode_e           mode_q   [NUM_CH];
  afv_mode_e           mode_d   [NUM_CH];
  logic [15:0]         word_q   [NUM_CH];
  logic [15:0]         word_d   [NUM_CH];
  logic [SETTLE_W-1:0] settle_q [NUM_CH];
  logic [SETTLE_W-1:0] settle_d [NUM_CH];
  logic [ST_W-1:0]     status_q, status_d;
  logic [ST_W-1:0]     mask_q, mask_d;
  logic [ST_W-1:0]     set_ev, clr_ev;
  logic                wreq_q, wreq_d;
  logic [31:0]         rdata_q, rdata_d;
  logic                irq_q, irq_d;

  logic                req, wr_go;
  logic [15:0]         fmt_word;
  logic                fmt_ovf;
  logic [NUM_CH-1:0]   settling;
  afv_mode_e           conv_mode;

  localparam logic [SETTLE_W-1:0] SETTLE_LOAD = SETTLE_W'(SETTLE_CYC);

  assign req       = read | write;
  assign wr_go     = write & ~wreq_q;
  assign conv_mode = mode_q[conv.chan];

  // ----------------------------------------------------------------------
  // scaler
  // ----------------------------------------------------------------------
  afv_fmt u_fmt (
    .raw  (conv.raw),
    .err  (conv.err),
    .mode (conv_mode),
    .word (fmt_word),
    .ovf  (fmt_ovf)
  );

  // ----------------------------------------------------------------------
  // channel next state
  // ----------------------------------------------------------------------
  always_comb begin
    set_ev = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      code_d[i]   = code_q[i];
      mode_d[i]   = mode_q[i];
      word_d[i]   = word_q[i];
      settle_d[i] = settle_q[i];
      settling[i] = settle_q[i] != '0;
      if (settling[i])
        settle_d[i] = settle_q[i] - 1'b1;
      // results during settling or on an off channel are dropped
      if (conv.valid && conv.chan == 2'(i) && mode_q[i] != MODE_OFF &&
          !settling[i]) begin
        word_d[i]        = fmt_word;
        set_ev[ST_DONE+i] = 1'b1;
        if (fmt_ovf)
          set_ev[ST_OVF+i] = 1'b1;
      end
      // a configuration write wins over a result in the same cycle
      if (wr_go && address == IDX_CODE0 + 4'(i) &&
          writedata[7:0] != FN_KEEP) begin
        if (fn_legal(writedata[7:0])) begin
          code_d[i]   = writedata[7:0];
          mode_d[i]   = fn_mode(writedata[7:0]);
          settle_d[i] = SETTLE_LOAD;
          word_d[i]   = WORD_BUSY;
          set_ev[ST_DONE+i] = 1'b0;
          set_ev[ST_OVF+i]  = 1'b0;
        end else begin
          set_ev[ST_PERR] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_CH; i++) begin
        code_q[i]   <= FN_RESET;
        mode_q[i]   <= MODE_STD_BIP;
        word_q[i]   <= WORD_RESET;
        settle_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        code_q[i]   <= code_d[i];
        mode_q[i]   <= mode_d[i];
        word_q[i]   <= word_d[i];
        settle_q[i] <= settle_d[i];
      end
    end
  end

  // ----------------------------------------------------------------------
  // events, mask and interrupt
  // ----------------------------------------------------------------------
  always_comb begin
    clr_ev = '0;
    mask_d = mask_q;
    if (wr_go && address == IDX_STATUS)
      clr_ev = writedata[ST_W-1:0];
    if (wr_go && address == IDX_MASK)
      mask_d = writedata[ST_W-1:0];
    // a new event in the clearing cycle stays set
    status_d = (status_q & ~clr_ev) | set_ev;
    irq_d    = |(status_d & mask_d);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= '0;
      mask_q   <= '0;
      irq_q    <= 1'b0;
    end else begin
      status_q <= status_d;
      mask_q   <= mask_d;
      irq_q    <= irq_d;
    end
  end

  // ----------------------------------------------------------------------
  // avalon slave: one wait cycle, read data loaded as waitrequest drops
  // ----------------------------------------------------------------------
  always_comb begin
    wreq_d  = ~(req & wreq_q);
    rdata_d = rdata_q;
    if (read && wreq_q) begin
      rdata_d = '0;
      if (address < IDX_WORD0)
        rdata_d = {24'h000000, code_q[address[1:0]]};
      else if (address < IDX_STATUS)
        rdata_d = {16'h0000, word_q[address[1:0]]};
      else if (address == IDX_STATUS)
        rdata_d = 32'(status_q);
      else if (address == IDX_MASK)
        rdata_d = 32'(mask_q);
      else if (address == IDX_SETTLE)
        rdata_d = 32'(settling);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wreq_q  <= 1'b1;
      rdata_q <= '0;
    end else begin
      wreq_q  <= wreq_d;
      rdata_q <= rdata_d;
    end
  end

  assign readdata    = rdata_q;
  assign waitrequest = wreq_q;
  assign irq         = irq_q;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic upd0;
  assign upd0 = conv.valid && conv.chan == 2'd0 && !settling[0] &&
                mode_q[0] != MODE_OFF &&
                !(wr_go && address == IDX_CODE0);

  a_settle_busy: assert property (
    settling[0] |-> word_q[0] == WORD_BUSY)
    else $error("settling channel shows a measurement");

  a_settle_load: assert property (
    wr_go && address == IDX_CODE0 && fn_legal(writedata[7:0]) &&
    writedata[7:0] != FN_KEEP |=> settle_q[0] == SETTLE_LOAD)
    else $error("settle window not loaded");

  a_off_hold: assert property (
    mode_q[0] == MODE_OFF && conv.valid && conv.chan == 2'd0 &&
    !(wr_go && address == IDX_CODE0) |=> $stable(word_q[0]))
    else $error("disabled channel updated");

  a_word_hold: assert property (
    !(conv.valid && conv.chan == 2'd0) &&
    !(wr_go && address == IDX_CODE0) |=> $stable(word_q[0]))
    else $error("word changed without a result");

  a_leg_flags: assert property (
    upd0 && mode_q[0] inside {MODE_LEG_2C, MODE_LEG_SM, MODE_LEG_LIVE}
    |=> word_q[0][2] == 1'b0 && word_q[0][1] == $past(conv.err))
    else $error("legacy status bits wrong");

  a_leg_ovf: assert property (
    upd0 && mode_q[0] == MODE_LEG_2C && conv.raw > 16'sd20480
    |=> word_q[0] == 16'h5001 || word_q[0] == 16'h5003)
    else $error("legacy overrun not saturated and flagged");

  a_std_range: assert property (
    upd0 && mode_q[0] == MODE_STD_BIP && conv.raw == 16'sh4000
    |=> word_q[0] == 16'h6C00)
    else $error("standard full scale wrong");

  a_sm_sign: assert property (
    upd0 && mode_q[0] == MODE_LEG_SM && conv.raw == -16'sd8192
    |=> word_q[0][15:3] == 13'h1400)
    else $error("sign-magnitude encoding wrong");

  a_irq_level: assert property (
    ##1 irq == |(status_q & mask_q))
    else $error("interrupt does not follow status and mask");

  a_wait_once: assert property (
    req && wreq_q |=> !waitrequest ##1 waitrequest)
    else $error("waitrequest not a single cycle answer");

  a_busy_load: assert property (
    wr_go && address == IDX_CODE0 && fn_legal(writedata[7:0]) &&
    writedata[7:0] != FN_KEEP |=> word_q[0] == WORD_BUSY)
    else $error("new configuration did not show the busy word");

  a_off_mode: assert property (
    wr_go && address == IDX_CODE0 && writedata[7:0] == FN_OFF
    |=> mode_q[0] == MODE_OFF)
    else $error("off code did not disable the channel");

  // code 00 must leave the stored configuration alone
  a_keep_code: assert property (
    wr_go && address == IDX_CODE0 && writedata[7:0] == FN_KEEP
    |=> $stable(code_q[0]) && $stable(mode_q[0]))
    else $error("keep code changed the configuration");

  a_std_clamp: assert property (
    upd0 && mode_q[0] == MODE_STD_BIP && conv.raw > 16'sd19300
    |=> word_q[0] == 16'h7EFF)
    else $error("standard overrange not saturated");

  a_std_floor: assert property (
    upd0 && mode_q[0] == MODE_STD_BIP && conv.raw < -16'sd19300
    |=> word_q[0] == 16'h8100)
    else $error("standard underrange not saturated");

  a_std_neg: assert property (
    upd0 && mode_q[0] == MODE_STD_BIP && conv.raw == -16'sd16384
    |=> word_q[0] == 16'h9400)
    else $error("standard negative full scale wrong");

  a_std_half: assert property (
    upd0 && mode_q[0] == MODE_STD_BIP && conv.raw == -16'sd8192
    |=> word_q[0] == 16'hCA00)
    else $error("standard half negative scale wrong");

  a_std_live: assert property (
    upd0 && mode_q[0] == MODE_STD_LIVE && conv.raw == 16'sh4000
    |=> word_q[0] == 16'h6C00)
    else $error("standard live zero full scale wrong");

  a_live_span: assert property (
    upd0 && mode_q[0] == MODE_LEG_LIVE && conv.raw == 16'sh4000
    |=> word_q[0][15:3] == 13'h0800)
    else $error("legacy live zero full scale wrong");

  a_done_set: assert property (
    upd0 |=> status_q[ST_DONE])
    else $error("accepted result did not set its done bit");

  // set wins over clear, so only a clear write may drop the bit
  a_perr_sticky: assert property (
    status_q[ST_PERR] &&
    !(wr_go && address == IDX_STATUS && writedata[ST_PERR])
    |=> status_q[ST_PERR])
    else $error("sticky error bit lost without a clear");

  a_perr_set: assert property (
    wr_go && address == IDX_CODE0 && !fn_legal(writedata[7:0]) &&
    writedata[7:0] != FN_KEEP |=> status_q[ST_PERR])
    else $error("illegal code not flagged");

  a_rdata_hold: assert property (
    !(read && wreq_q) |=> $stable(readdata))
    else $error("read data changed without a read");

  c_leg_update: cover property (upd0 && mode_q[0] == MODE_LEG_SM);
  c_cfg_write:  cover property (wr_go && address == IDX_CODE0);
  c_irq_rise:   cover property ($rose(irq));
  c_std_update: cover property (upd0 && mode_q[0] == MODE_STD_LIVE);
  c_off_drop:   cover property (mode_q[0] == MODE_OFF && conv.valid &&
                                conv.chan == 2'd0);

endmodule
`default_nettype wire

/* File: rtl/afv_pkg.sv */
/*
 * analog value formatter: shared constants, types and decode helpers.
 * assumes one 40 MHz clock; register map indexes are avalon word addresses.
 */
package afv_pkg;

  // ----------------------------------------------------------------------
  // sizes and timing
  // ----------------------------------------------------------------------
  localparam int unsigned NUM_CH       = 4;
  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned SETTLE_MS    = 60;
  localparam int unsigned SETTLE_CYC   = CLK_HZ / 1000 * SETTLE_MS;
  localparam int unsigned SETTLE_W     = 22;

  // ----------------------------------------------------------------------
  // register map (word index on the avalon address)
  // ----------------------------------------------------------------------
  localparam logic [3:0] IDX_CODE0     = 4'h0;
  localparam logic [3:0] IDX_WORD0     = 4'h4;
  localparam logic [3:0] IDX_STATUS    = 4'h8;
  localparam logic [3:0] IDX_MASK      = 4'h9;
  localparam logic [3:0] IDX_SETTLE    = 4'hA;
  localparam int unsigned ST_DONE      = 0;
  localparam int unsigned ST_OVF       = 4;
  localparam int unsigned ST_PERR      = 8;
  localparam int unsigned ST_W         = 9;

  // ----------------------------------------------------------------------
  // function codes and output words
  // ----------------------------------------------------------------------
  localparam logic [7:0]  FN_KEEP      = 8'h00;
  localparam logic [7:0]  FN_STD_BIP   = 8'h28;
  localparam logic [7:0]  FN_STD_LIVE  = 8'h2C;
  localparam logic [7:0]  FN_LEG_SM    = 8'h2B;
  localparam logic [7:0]  FN_LEG_LIVE  = 8'h2D;
  localparam logic [7:0]  FN_LEG_2C    = 8'h3B;
  localparam logic [7:0]  FN_OFF       = 8'hFF;
  localparam logic [7:0]  FN_RESET     = FN_STD_BIP;
  localparam logic [15:0] WORD_BUSY    = 16'h7FFF;
  localparam logic [15:0] WORD_RESET   = 16'h0000;

  // ----------------------------------------------------------------------
  // scaling limits
  // ----------------------------------------------------------------------
  localparam int LEG_MAX   = 20480;
  localparam int LEG_MIN   = -20480;
  localparam int STD_MAX   = 32511;
  localparam int STD_MIN   = -32512;
  localparam int LIVE_LEG  = 4096;
  localparam int LIVE_STD  = 6912;

  typedef enum logic [2:0] {
    MODE_STD_BIP, MODE_STD_LIVE, MODE_LEG_2C, MODE_LEG_SM, MODE_LEG_LIVE,
    MODE_OFF
  } afv_mode_e;

  // one result from the converter front end
  typedef struct packed {
    logic              valid;
    logic [1:0]        chan;
    logic              err;
    logic signed [15:0] raw;
  } afv_conv_s;

  function automatic logic fn_legal(input logic [7:0] code);
    return code == FN_STD_BIP || code == FN_STD_LIVE || code == FN_LEG_SM ||
           code == FN_LEG_LIVE || code == FN_LEG_2C || code == FN_OFF;
  endfunction

  function automatic afv_mode_e fn_mode(input logic [7:0] code);
    afv_mode_e m;
    m = MODE_OFF;
    if (code == FN_STD_BIP)  m = MODE_STD_BIP;
    if (code == FN_STD_LIVE) m = MODE_STD_LIVE;
    if (code == FN_LEG_SM)   m = MODE_LEG_SM;
    if (code == FN_LEG_LIVE) m = MODE_LEG_LIVE;
    if (code == FN_LEG_2C)   m = MODE_LEG_2C;
    return m;
  endfunction

endpackage

/* File: rtl/afv_fmt.sv */
/*
 * combinational scaler: one raw sample into a 16-bit image word.
 * assumes raw full scale 16384 at the top of the range; live-zero ranges
 * put their zero point at one fifth of that span.
 */
`timescale 1ns/1ps
`default_nettype none
module afv_fmt (
  // sample in
  input  wire logic signed [15:0] raw,
  input  wire logic               err,
  input  wire afv_pkg::afv_mode_e mode,
  // word out
  output logic [15:0]             word,
  output logic                    ovf
);
  import afv_pkg::*;

  logic signed [31:0] v;
  logic signed [31:0] s;
  logic [14:0]        mag;
  logic               leg;

  always_comb begin
    v   = 32'(raw);
    ovf = 1'b0;
    leg = 1'b0;
    unique case (mode)
      MODE_STD_BIP:  v = (32'(raw) * 27) >>> 4;
      MODE_STD_LIVE: v = ((32'(raw) * 135) >>> 6) - LIVE_STD;
      MODE_LEG_2C,
      MODE_LEG_SM: begin
        v   = 32'(raw);
        leg = 1'b1;
      end
      MODE_LEG_LIVE: begin
        v   = ((32'(raw) * 5) >>> 2) - LIVE_LEG;
        leg = 1'b1;
      end
      MODE_OFF:      v = 32'sd0;
    endcase
    s = v;
    if (leg) begin
      if (v > LEG_MAX) begin
        s   = LEG_MAX;
        ovf = 1'b1;
      end else if (v < LEG_MIN) begin
        s   = LEG_MIN;
        ovf = 1'b1;
      end
    end else begin
      if (v > STD_MAX) s = STD_MAX;
      else if (v < STD_MIN) s = STD_MIN;
    end
    mag = s[31] ? 15'(-s) : s[14:0];
    if (mode == MODE_LEG_SM)
      word = {s[31], mag[14:3], 3'b000};
    else if (leg)
      word = {s[15:3], 3'b000};
    else
      word = s[15:0];
    if (leg)
      word[2:0] = {1'b0, err, ovf};
  end

endmodule
`default_nettype wire

/* File: tb/afv_conv_src.sv */
/*
 converter front end model: one result pulse for each request.
 assumes requests are raised by the bench just after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module afv_conv_src (
  // request
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic [1:0]  ch,
  input  wire logic        err,
  input  wire logic [15:0] raw,
  // result
  output afv_pkg::afv_conv_s conv
);
  import afv_pkg::*;
  initial conv = '0;
  // between results the sample lines toggle so no stale value can pass
  always @(posedge clk) begin
    conv.valid <= go;
    conv.chan  <= ch;
    conv.err   <= err;
    conv.raw   <= go ? raw : ~conv.raw;
  end
endmodule
`default_nettype wire

/* File: tb/analog_value_formatter_test.sv */
/*
 self-checking bench for the analog value formatter top.
 assumes afv_pkg and afv_top; settling shortened to keep runs short.
*/
`timescale 1ns/1ps
`default_nettype none
module analog_value_formatter_test;
  import afv_pkg::*;
  localparam int unsigned ST = 20;
  logic        clk, nrst, read, write, waitrequest, irq, go, cerr;
  logic [3:0]  address;
  logic [31:0] writedata, readdata, q;
  logic [1:0]  cch;
  logic [15:0] craw;
  afv_conv_s   conv;
  int          failures, n_tests, seed;
  logic [7:0]  codes [5] = '{FN_STD_BIP, FN_STD_LIVE, FN_LEG_SM,
                             FN_LEG_LIVE, FN_LEG_2C};

  afv_top #(.SETTLE_CYC(ST)) afv_top_inst (.clk(clk), .nrst(nrst),
    .conv(conv), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .irq(irq));
  afv_conv_src afv_conv_src_inst (.clk(clk), .go(go), .ch(cch),
    .err(cerr), .raw(craw), .conv(conv));

  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // expectation and checking
  // ----------------------------------------------------------------
  function automatic logic [15:0] exp_word(logic [7:0] c, logic [15:0] r,
                                           logic e);
    int   v;
    logic ov;
    v = $signed(r);
    ov = 0;
    if (c == FN_STD_BIP || c == FN_STD_LIVE) begin
      v = (c == FN_STD_BIP) ? (v * 27) >>> 4 : ((v * 135) >>> 6) - 6912;
      if (v > 32511) v = 32511;
      if (v < -32512) v = -32512;
      return v[15:0];
    end
    if (c == FN_LEG_LIVE) v = v * 5 / 4 - 4096;
    if (v > 20480) begin
      v = 20480;
      ov = 1;
    end
    if (v < -20480) begin
      v = -20480;
      ov = 1;
    end
    // sign bit on top of the magnitude
    if (c == FN_LEG_SM && v < 0) v = 32768 - v;
    return {v[15:3], 1'b0, e, ov};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // bus and converter drivers
  // ----------------------------------------------------------------
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= d;
    // hold until an edge samples waitrequest low; a hang is left to the
    // watchdog
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    q = readdata;
    read <= 0;
    write <= 0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    bus(0, a, 32'h0);
    chk(q, exp);
  endtask

  task automatic cfg(input logic [1:0] ch, input logic [7:0] c);
    bus(1, IDX_CODE0 + {2'h0, ch}, {24'h0, c});
  endtask

  task automatic smp(input logic [1:0] ch, input logic e,
                     input logic [15:0] r);
    cch <= ch;
    cerr <= e;
    craw <= r;
    go <= 1;
    @(posedge clk);
    go <= 0;
    repeat (3) @(posedge clk);
  endtask

  task automatic corner(input logic [7:0] c, input logic e,
                        input logic [15:0] r, input logic [15:0] exp);
    cfg(0, c);
    repeat (ST + 5) @(posedge clk);
    smp(0, e, r);
    rd(IDX_WORD0, {16'h0, exp});
  endtask

  task automatic conclude;
    $display("failures %0d, checks %0d", failures, n_tests);
    if (failures == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    logic [1:0]  ch;
    logic [7:0]  c;
    logic [15:0] r;
    logic        e;
    nrst = 0; read = 0; write = 0; address = 0; writedata = 0;
    go = 0; cch = 0; cerr = 0; craw = 0;
    failures = 0; n_tests = 0; seed = 49238;
    repeat (10) @(posedge clk);
    nrst <= 1;
    repeat (3) @(posedge clk);
    rd(IDX_CODE0, 32'h28);
    rd(IDX_WORD0, 32'h0);
    bus(1, IDX_CODE0, 32'h55);
    rd(IDX_CODE0, 32'h28);
    rd(IDX_STATUS, 32'h100);
    chk({31'h0, irq}, 32'h0);
    bus(1, IDX_MASK, 32'h1FF);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    bus(1, IDX_STATUS, 32'h100);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    cfg(0, FN_LEG_2C);
    smp(0, 0, 16'h1000);
    rd(IDX_WORD0, 32'h7FFF);
    rd(IDX_SETTLE, 32'h1);
    repeat (ST + 5) @(posedge clk);
    smp(0, 0, 16'h7FFF);
    rd(IDX_WORD0, 32'h5001);
    rd(IDX_STATUS, 32'h011);
    chk({31'h0, irq}, 32'h1);
    bus(1, IDX_STATUS, 32'h1FF);
    corner(FN_STD_BIP, 0, 16'h4000, 16'h6C00);
    corner(FN_STD_BIP, 0, 16'hC000, 16'h9400);
    corner(FN_LEG_2C, 0, 16'hE000, 16'hE000);
    corner(FN_LEG_2C, 1, 16'h2000, 16'h2002);
    corner(FN_LEG_SM, 0, 16'hE000, 16'hA000);
    corner(FN_LEG_SM, 0, 16'hC000, 16'hC000);
    corner(FN_STD_LIVE, 0, 16'h4000, 16'h6C00);
    corner(FN_LEG_LIVE, 0, 16'h4000, 16'h4000);
    corner(FN_LEG_LIVE, 0, 16'h2667, 16'h2000);
    corner(FN_LEG_SM, 0, 16'h2000, 16'h2000);
    corner(FN_LEG_SM, 0, 16'h8000, 16'hD001);
    corner(FN_STD_BIP, 0, 16'hE000, 16'hCA00);
    corner(FN_STD_LIVE, 0, 16'h0CCD, 16'h0000);
    corner(FN_STD_BIP, 0, 16'h7FFF, 16'h7EFF);
    corner(FN_STD_BIP, 0, 16'h8000, 16'h8100);
    cfg(0, FN_OFF);
    repeat (ST + 5) @(posedge clk);
    smp(0, 0, 16'h1000);
    rd(IDX_WORD0, 32'h7FFF);
    cfg(0, FN_KEEP);
    rd(IDX_CODE0, 32'hFF);
    rd(4'hF, 32'h0);
    // random codes and samples; live legacy kept on the positive side
    repeat (30) begin
      ch = 2'($random(seed));
      c = codes[$unsigned($random(seed)) % 5];
      cfg(ch, c);
      rd(IDX_WORD0 + {2'h0, ch}, 32'h7FFF);
      repeat (ST + 5) @(posedge clk);
      repeat (3) begin
        r = 16'($random(seed));
        e = 1'($random(seed));
        if (c == FN_LEG_LIVE) r = 16'd3280 + {2'h0, r[11:0], 2'h0};
        smp(ch, e, r);
        rd(IDX_WORD0 + {2'h0, ch}, {16'h0, exp_word(c, r, e)});
      end
    end
    conclude();
  end

  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    conclude();
  end
endmodule
`default_nettype wire
